/* rtl/lrsec_regs.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef LRSEC_REGS_SVH
`define LRSEC_REGS_SVH
// Register word offsets in bytes.
`define LRSEC_CTRL_OFS      8'h00
`define LRSEC_STATUS_OFS    8'h04
`define LRSEC_CMD_OFS       8'h08
`define LRSEC_ARG0_OFS      8'h0C
`define LRSEC_ARG1_OFS      8'h10
`define LRSEC_RESULT_OFS    8'h14
`define LRSEC_PWD_OFS       8'h18
`define LRSEC_CFG_OFS       8'h1C
`define LRSEC_TXDATA_OFS    8'h20
`define LRSEC_INFO0_OFS     8'h24
`define LRSEC_INFO1_OFS     8'h28
`define LRSEC_INFO2_OFS     8'h2C
`define LRSEC_INFO3_OFS     8'h30
`define LRSEC_INFO4_OFS     8'h34
`define LRSEC_APPVER_OFS    8'h38
`define LRSEC_FLSTAT_OFS    8'h3C
// Control register bit positions.
`define LRSEC_CTRL_GO_BIT       0
`define LRSEC_CTRL_TIMEOUT_BIT  1
`define LRSEC_CTRL_FLERR_BIT    2
`define LRSEC_CTRL_START_BIT    3
`define LRSEC_CTRL_DEVBUSY_BIT  4
// Configuration register field positions.
`define LRSEC_CFG_READOUT_BIT   0
`define LRSEC_CFG_FR_LO         1
`define LRSEC_CFG_FR_HI         2
`define LRSEC_CFG_ALERT_LO      3
`define LRSEC_CFG_ALERT_HI      4
`define LRSEC_CFG_WPMAIN_BIT    5
`define LRSEC_CFG_WPCFG_BIT     6
`define LRSEC_CFG_LDREN_BIT     7
`define LRSEC_CFG_RST           8'h80
// Packet constants.
`define LRSEC_HDR               8'h08
`define LRSEC_ACK               8'h00
`define LRSEC_RSP_READ          8'h30
`define LRSEC_RSP_INFO          8'h31
`define LRSEC_RSP_CRC           8'h32
`define LRSEC_RSP_DETAIL        8'h3A
`define LRSEC_RSP_MSG           8'h3B
`define LRSEC_LEN_MSG           8'h02
`define LRSEC_LEN_INFO          8'h19
`define LRSEC_LEN_CRC           8'h05
`define LRSEC_FLASH_ERR         8'hF0
`define LRSEC_MAX_FAILS         2'h3
`define LRSEC_MIN_CRC_LEN       32'h0000_0400
`define LRSEC_MAX_BUF           16'h06C0
// Back-off time after a wrong password.
`define LRSEC_BACKOFF_MS        2000
`define LRSEC_CLK_MHZ           100
`define LRSEC_BACKOFF_CYC       (`LRSEC_BACKOFF_MS * 1000 * `LRSEC_CLK_MHZ)
`endif

/* rtl/lrsec_pkg.sv */
// Types shared by the loader response and security block.
package lrsec_pkg;
  typedef enum logic [3:0] {
    LRSEC_ST_OK        = 4'h0,
    LRSEC_ST_LOCKED    = 4'h1,
    LRSEC_ST_PWD       = 4'h2,
    LRSEC_ST_ALERT     = 4'h3,
    LRSEC_ST_UNKNOWN   = 4'h4,
    LRSEC_ST_RANGE     = 4'h5,
    LRSEC_ST_INVALID   = 4'h6,
    LRSEC_ST_FR_OFF    = 4'h7,
    LRSEC_ST_FR_PWD    = 4'h8,
    LRSEC_ST_READOUT   = 4'h9,
    LRSEC_ST_ALIGN     = 4'hA,
    LRSEC_ST_CRC_LEN   = 4'hB
  } lrsec_status_e;
  typedef enum logic [7:0] {
    LRSEC_CMD_CONNECT  = 8'h12,
    LRSEC_CMD_UNLOCK   = 8'h21,
    LRSEC_CMD_PROGRAM  = 8'h20,
    LRSEC_CMD_PROGFAST = 8'h24,
    LRSEC_CMD_READ     = 8'h29,
    LRSEC_CMD_ERASE    = 8'h23,
    LRSEC_CMD_MASS     = 8'h15,
    LRSEC_CMD_FACTORY  = 8'h30,
    LRSEC_CMD_VERIFY   = 8'h26,
    LRSEC_CMD_START    = 8'h40,
    LRSEC_CMD_BAUD     = 8'h52,
    LRSEC_CMD_INFO     = 8'h19
  } lrsec_cmd_e;
  typedef enum logic [2:0] {
    LRSEC_FSM_IDLE  = 3'b000,
    LRSEC_FSM_ACK   = 3'b001,
    LRSEC_FSM_HEAD  = 3'b010,
    LRSEC_FSM_BODY  = 3'b011,
    LRSEC_FSM_CRC   = 3'b100,
    LRSEC_FSM_WAIT  = 3'b101
  } lrsec_fsm_e;
  typedef enum logic [1:0] {
    LRSEC_ALERT_ERASE   = 2'h0,
    LRSEC_ALERT_DISABLE = 2'h1,
    LRSEC_ALERT_NONE    = 2'h2
  } lrsec_alert_e;
  typedef enum logic [1:0] {
    LRSEC_FR_ON   = 2'h0,
    LRSEC_FR_PWD  = 2'h1,
    LRSEC_FR_OFF  = 2'h2
  } lrsec_fr_e;
endpackage : lrsec_pkg

/* rtl/lrsec_core.sv */
// Loader response builder and security guard behind a Wishbone slave.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "lrsec_regs.svh"

module lrsec_core #(
  parameter int unsigned BACKOFF_CYC = `LRSEC_BACKOFF_CYC
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  input  wire logic        boot_start,
  input  wire logic [31:0] crc_in,
  input  wire logic [31:0] read_word,
  output logic      [31:0] read_addr,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  output logic             tx_crc_go,
  output logic             erase_main,
  output logic             erase_cfg,
  output logic             loader_exit,
  output logic             loader_active
);

  // Register bank.
  logic [7:0]  cmd_q;
  logic [31:0] arg0_q, arg1_q, pwd_q, txw_q, appver_q;
  logic [31:0] info_q [5];
  logic [7:0]  cfg_q;
  logic [15:0] flstat_q;
  logic        unlocked_q, connected_q, active_q;
  logic [1:0]  fails_q;
  logic [31:0] backoff_q;
  logic [7:0]  result_q;
  lrsec_pkg::lrsec_fsm_e fsm_q, fsm_d;
  logic [7:0]  kind_q, len_q, idx_q;
  logic [7:0]  body_q [8];
  logic        erase_m_q, erase_c_q, exit_q, go_pend_q, flerr_q;

  // Bus decode.
  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr   = bus_req & wb_we_i & (&wb_sel_i);
  wire busy     = (fsm_q != lrsec_pkg::LRSEC_FSM_IDLE);
  wire blocked  = (backoff_q != 32'h0);
  wire go       = bus_wr & (wb_adr_i == `LRSEC_CTRL_OFS)
                  & wb_dat_i[`LRSEC_CTRL_GO_BIT] & ~busy;
  wire tmo      = bus_wr & (wb_adr_i == `LRSEC_CTRL_OFS)
                  & wb_dat_i[`LRSEC_CTRL_TIMEOUT_BIT];
  wire flerr    = bus_wr & (wb_adr_i == `LRSEC_CTRL_OFS)
                  & wb_dat_i[`LRSEC_CTRL_FLERR_BIT];

  // Configuration fields.
  wire        readout_en = cfg_q[`LRSEC_CFG_READOUT_BIT];
  wire [1:0]  fr_mode    = cfg_q[`LRSEC_CFG_FR_HI:`LRSEC_CFG_FR_LO];
  wire [1:0]  alert_mode = cfg_q[`LRSEC_CFG_ALERT_HI:`LRSEC_CFG_ALERT_LO];
  wire        wp_main    = cfg_q[`LRSEC_CFG_WPMAIN_BIT];
  wire        wp_cfg     = cfg_q[`LRSEC_CFG_WPCFG_BIT];
  wire        loader_en  = cfg_q[`LRSEC_CFG_LDREN_BIT];

  // Commands that touch memory need an unlock first.
  function automatic logic is_protected(input logic [7:0] c);
    case (c)
      lrsec_pkg::LRSEC_CMD_PROGRAM, lrsec_pkg::LRSEC_CMD_PROGFAST,
      lrsec_pkg::LRSEC_CMD_READ,    lrsec_pkg::LRSEC_CMD_ERASE,
      lrsec_pkg::LRSEC_CMD_MASS,    lrsec_pkg::LRSEC_CMD_FACTORY,
      lrsec_pkg::LRSEC_CMD_VERIFY:  is_protected = 1'b1;
      default:                      is_protected = 1'b0;
    endcase
  endfunction : is_protected

  function automatic logic is_known(input logic [7:0] c);
    case (c)
      lrsec_pkg::LRSEC_CMD_CONNECT, lrsec_pkg::LRSEC_CMD_UNLOCK,
      lrsec_pkg::LRSEC_CMD_START,   lrsec_pkg::LRSEC_CMD_BAUD,
      lrsec_pkg::LRSEC_CMD_INFO:    is_known = 1'b1;
      default:                      is_known = is_protected(c);
    endcase
  endfunction : is_known

  // Status verdict for the pending command; 0xFF means a data answer.
  wire pwd_ok    = (arg0_q == pwd_q);
  wire third     = (fails_q == (`LRSEC_MAX_FAILS - 2'h1));
  wire is_prog   = (cmd_q == lrsec_pkg::LRSEC_CMD_PROGRAM) |
                   (cmd_q == lrsec_pkg::LRSEC_CMD_PROGFAST);
  wire misalign  = (arg0_q[2:0] != 3'h0) | (arg1_q[2:0] != 3'h0);
  wire badrange  = (arg1_q > {16'h0, `LRSEC_MAX_BUF});
  logic [7:0] verdict;
  always_comb
  begin
    verdict = 8'hFF;
    if (!is_known(cmd_q))
      verdict = {4'h0, lrsec_pkg::LRSEC_ST_UNKNOWN};
    else if (!connected_q && cmd_q != lrsec_pkg::LRSEC_CMD_CONNECT)
      verdict = {4'h0, lrsec_pkg::LRSEC_ST_INVALID};
    else if (is_protected(cmd_q) && !unlocked_q)
      verdict = {4'h0, lrsec_pkg::LRSEC_ST_LOCKED};
    else
      case (cmd_q)
        lrsec_pkg::LRSEC_CMD_UNLOCK:
          if (pwd_ok)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_OK};
          else if (third)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_ALERT};
          else
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_PWD};
        lrsec_pkg::LRSEC_CMD_READ:
          if (!readout_en)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_READOUT};
          else if (badrange)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_RANGE};
        lrsec_pkg::LRSEC_CMD_VERIFY:
          if (arg1_q < `LRSEC_MIN_CRC_LEN)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_CRC_LEN};
        lrsec_pkg::LRSEC_CMD_FACTORY:
          if (fr_mode == lrsec_pkg::LRSEC_FR_OFF)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_FR_OFF};
          else if (fr_mode == lrsec_pkg::LRSEC_FR_PWD && !pwd_ok)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_FR_PWD};
          else
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_OK};
        lrsec_pkg::LRSEC_CMD_INFO:
          verdict = 8'hFF;
        default:
          if (is_prog && misalign)
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_ALIGN};
          else
            verdict = {4'h0, lrsec_pkg::LRSEC_ST_OK};
      endcase
  end

  // Answer kind and length: status, data, or no core answer at all.
  wire fast_ok  = (cmd_q == lrsec_pkg::LRSEC_CMD_PROGFAST) & (verdict == 8'h0);
  wire silent   = fast_ok | (cmd_q == lrsec_pkg::LRSEC_CMD_START)
                  | (cmd_q == lrsec_pkg::LRSEC_CMD_BAUD)
                  | (cmd_q == lrsec_pkg::LRSEC_CMD_CONNECT);
  wire is_data  = (verdict == 8'hFF);
  wire [7:0] sel_kind = go_pend_q & flerr_q ? `LRSEC_RSP_DETAIL :
                        !is_data ? `LRSEC_RSP_MSG :
                        cmd_q == lrsec_pkg::LRSEC_CMD_INFO ? `LRSEC_RSP_INFO :
                        cmd_q == lrsec_pkg::LRSEC_CMD_VERIFY ? `LRSEC_RSP_CRC :
                        `LRSEC_RSP_READ;
  wire [7:0] sel_len  = (sel_kind == `LRSEC_RSP_MSG)  ? `LRSEC_LEN_MSG :
                        (sel_kind == `LRSEC_RSP_DETAIL) ? 8'h04 :
                        (sel_kind == `LRSEC_RSP_INFO) ? `LRSEC_LEN_INFO :
                        (sel_kind == `LRSEC_RSP_CRC)  ? `LRSEC_LEN_CRC :
                        arg1_q[7:0] + 8'h01;

  // Byte served in the body, chosen by index within the answer.
  logic [7:0] body_byte;
  wire  [7:0] bi = idx_q - 8'h01;
  // Info word 1 is the application version, so later words shift down one.
  wire  [2:0] info_w = (bi[4:2] == 3'h0) ? 3'h0 : bi[4:2] - 3'h1;
  always_comb
  begin
    body_byte = 8'h00;
    case (kind_q)
      `LRSEC_RSP_MSG:    body_byte = result_q;
      `LRSEC_RSP_DETAIL:
        body_byte = (bi == 8'h0) ? `LRSEC_FLASH_ERR :
                    (bi == 8'h1) ? flstat_q[7:0] :
                    (bi == 8'h2) ? flstat_q[15:8] : 8'h00;
      `LRSEC_RSP_CRC:    body_byte = crc_in[8*bi[1:0] +: 8];
      `LRSEC_RSP_INFO:
        body_byte = (bi[7:2] == 6'h1) ? appver_q[8*bi[1:0] +: 8] :
                    info_q[info_w][8*bi[1:0] +: 8];
      default:           body_byte = read_word[8*bi[1:0] +: 8];
    endcase
  end

  // A byte counts as sent only once it was offered and the sink took it.
  wire sending = (fsm_q == lrsec_pkg::LRSEC_FSM_ACK) |
                 (fsm_q == lrsec_pkg::LRSEC_FSM_HEAD) |
                 (fsm_q == lrsec_pkg::LRSEC_FSM_BODY);
  wire step    = sending & tx_valid & tx_ready;

  // Transmit sequencer: acknowledgement, header, length, code, body.
  logic [7:0] tx_byte;
  always_comb
  begin
    fsm_d = fsm_q;
    tx_byte = 8'h00;
    case (fsm_q)
      lrsec_pkg::LRSEC_FSM_IDLE:
        if (go_pend_q)
          fsm_d = lrsec_pkg::LRSEC_FSM_ACK;
      lrsec_pkg::LRSEC_FSM_ACK:
      begin
        tx_byte = `LRSEC_ACK;
        if (step)
          fsm_d = silent && !flerr_q ? lrsec_pkg::LRSEC_FSM_WAIT
                                     : lrsec_pkg::LRSEC_FSM_HEAD;
      end
      lrsec_pkg::LRSEC_FSM_HEAD:
      begin
        tx_byte = (idx_q == 8'h0) ? `LRSEC_HDR : (idx_q == 8'h1) ? len_q :
                  (idx_q == 8'h2) ? 8'h00 : kind_q;
        if (step && idx_q == 8'h3)
          fsm_d = lrsec_pkg::LRSEC_FSM_BODY;
      end
      lrsec_pkg::LRSEC_FSM_BODY:
      begin
        tx_byte = body_byte;
        if (step && idx_q == len_q - 8'h01)
          fsm_d = lrsec_pkg::LRSEC_FSM_CRC;
      end
      lrsec_pkg::LRSEC_FSM_CRC:
        fsm_d = lrsec_pkg::LRSEC_FSM_WAIT;
      lrsec_pkg::LRSEC_FSM_WAIT:
        fsm_d = lrsec_pkg::LRSEC_FSM_IDLE;
      default:
        fsm_d = lrsec_pkg::LRSEC_FSM_IDLE;
    endcase
  end

  wire unlock_cmd = (cmd_q == lrsec_pkg::LRSEC_CMD_UNLOCK) & connected_q;
  wire accept  = go_pend_q & ~busy;
  wire wrong   = accept & unlock_cmd & ~pwd_ok;
  wire alert   = wrong & third;

  // Sequencer registers.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      fsm_q <= lrsec_pkg::LRSEC_FSM_IDLE;
      idx_q <= 8'h00;
      kind_q <= 8'h00;
      len_q <= 8'h00;
      result_q <= 8'h00;
    end
    else
    begin
      fsm_q <= fsm_d;
      if (accept)
      begin
        kind_q <= sel_kind;
        len_q <= sel_len;
        result_q <= verdict;
      end
      if (fsm_q == lrsec_pkg::LRSEC_FSM_ACK || fsm_d != fsm_q)
        idx_q <= (fsm_d == lrsec_pkg::LRSEC_FSM_BODY) ? 8'h01 : 8'h00;
      else if (step)
        idx_q <= idx_q + 8'h01;
    end
  end

  // Security state: lock, connection, failure count, back-off, alert.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      unlocked_q <= 1'b0;
      connected_q <= 1'b0;
      fails_q <= 2'h0;
      backoff_q <= 32'h0;
      erase_m_q <= 1'b0;
      erase_c_q <= 1'b0;
      exit_q <= 1'b0;
      active_q <= 1'b0;
      go_pend_q <= 1'b0;
      flerr_q <= 1'b0;
      cfg_q <= `LRSEC_CFG_RST;
    end
    else
    begin
      if (boot_start && loader_en && !exit_q)
        active_q <= 1'b1;
      if (go && !blocked && active_q)
      begin
        go_pend_q <= 1'b1;
        flerr_q <= 1'b0;
      end
      else if (accept)
        go_pend_q <= 1'b0;
      if (flerr && !busy)
        flerr_q <= 1'b1;
      if (accept && cmd_q == lrsec_pkg::LRSEC_CMD_CONNECT)
        connected_q <= 1'b1;
      if (tmo)
        unlocked_q <= 1'b0;
      else if (accept && unlock_cmd && pwd_ok)
        unlocked_q <= 1'b1;
      if (accept && unlock_cmd)
        fails_q <= pwd_ok ? 2'h0 : (third ? 2'h0 : fails_q + 2'h1);
      if (wrong)
        backoff_q <= BACKOFF_CYC;
      else if (blocked)
        backoff_q <= backoff_q - 32'h1;
      if (alert && alert_mode == lrsec_pkg::LRSEC_ALERT_ERASE)
      begin
        erase_m_q <= ~wp_main;
        erase_c_q <= ~wp_cfg;
      end
      else
      begin
        erase_m_q <= 1'b0;
        erase_c_q <= 1'b0;
      end
      if (alert && alert_mode == lrsec_pkg::LRSEC_ALERT_DISABLE && !wp_cfg)
      begin
        cfg_q[`LRSEC_CFG_LDREN_BIT] <= 1'b0;
        exit_q <= 1'b1;
        active_q <= 1'b0;
      end
      else if (bus_wr && wb_adr_i == `LRSEC_CFG_OFS)
        cfg_q <= wb_dat_i[7:0];
    end
  end

  // Software-written words.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cmd_q <= 8'h00;
      arg0_q <= 32'h0;
      arg1_q <= 32'h0;
      pwd_q <= 32'h0;
      appver_q <= 32'h0;
      flstat_q <= 16'h0;
      for (int i = 0; i < 5; i++)
        info_q[i] <= 32'h0;
    end
    else if (bus_wr && !busy)
      case (wb_adr_i)
        `LRSEC_CMD_OFS:    cmd_q <= wb_dat_i[7:0];
        `LRSEC_ARG0_OFS:   arg0_q <= wb_dat_i;
        `LRSEC_ARG1_OFS:   arg1_q <= wb_dat_i;
        `LRSEC_PWD_OFS:    pwd_q <= wb_dat_i;
        `LRSEC_APPVER_OFS: appver_q <= wb_dat_i;
        `LRSEC_FLSTAT_OFS: flstat_q <= wb_dat_i[15:0];
        `LRSEC_INFO0_OFS:  info_q[0] <= wb_dat_i;
        `LRSEC_INFO1_OFS:  info_q[1] <= wb_dat_i;
        `LRSEC_INFO2_OFS:  info_q[2] <= wb_dat_i;
        `LRSEC_INFO3_OFS:  info_q[3] <= wb_dat_i;
        `LRSEC_INFO4_OFS:  info_q[4] <= wb_dat_i;
        default:           cmd_q <= cmd_q;
      endcase
  end

  // Read mux and acknowledge, one cycle after the strobe.
  wire [31:0] status_w = {8'h0, result_q, 4'h0, 1'b0, exit_q, blocked,
                          busy, 2'h0, fails_q, active_q, connected_q,
                          unlocked_q, 1'b0};
  wire [31:0] rd_mux = (wb_adr_i == `LRSEC_STATUS_OFS) ? status_w :
                       (wb_adr_i == `LRSEC_CFG_OFS) ? {24'h0, cfg_q} :
                       (wb_adr_i == `LRSEC_CMD_OFS) ? {24'h0, cmd_q} :
                       (wb_adr_i == `LRSEC_RESULT_OFS) ? {24'h0, result_q} :
                       32'h0;
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      tx_crc_go <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req && !wb_we_i ? rd_mux : 32'h0;
      tx_valid <= sending & ~step;
      tx_data <= tx_byte;
      tx_crc_go <= (fsm_q == lrsec_pkg::LRSEC_FSM_CRC);
    end
  end

  assign read_addr     = arg0_q + {24'h0, bi[7:2], 2'b00};
  assign erase_main    = erase_m_q;
  assign erase_cfg     = erase_c_q;
  assign loader_exit   = exit_q;
  assign loader_active = active_q;

endmodule : lrsec_core
`default_nettype wire

/* testbench/lrsec_core_properties.sv */
// Concurrent checks on the ports of the loader response block.
`timescale 1ns/1ps
`default_nettype none
module lrsec_core_properties (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       boot_start,
  input wire logic       tx_ready,
  input wire logic       tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic       tx_crc_go,
  input wire logic       erase_main,
  input wire logic       erase_cfg,
  input wire logic       loader_exit,
  input wire logic       loader_active
);
  // All checks use the one clock and pause while reset is held.
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  bus_answer_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  ack_pulse_a:
    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  byte_hold_a:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("offered byte changed before it was taken");
  byte_release_a:
    assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("byte offer not dropped after it was taken");
  trailer_pulse_a:
    assert property (tx_crc_go |=> !tx_crc_go)
    else $error("trailer request longer than one cycle");
  erase_pulse_a:
    assert property (erase_main || erase_cfg |=> !erase_main && !erase_cfg)
    else $error("erase request longer than one cycle");
  exit_hold_a:
    assert property (loader_exit |=> loader_exit)
    else $error("loader exit dropped without reset");
  entry_gate_a:
    assert property (!loader_active && !boot_start |=> !loader_active)
    else $error("loader became active without boot start");
endmodule : lrsec_core_properties
bind lrsec_core lrsec_core_properties i_lrsec_core_properties (
  .clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .boot_start, .tx_ready,
  .tx_valid, .tx_data, .tx_crc_go, .erase_main, .erase_cfg, .loader_exit,
  .loader_active
);
`default_nettype wire

/* testbench/lrsec_host_model.sv */
// Far-side model: a stalling byte sink plus memory and CRC sources.
`timescale 1ns/1ps
`default_nettype none
module lrsec_host_model (
  input  wire logic        clk,
  input  wire logic [31:0] read_addr,
  output logic      [31:0] read_word,
  output logic      [31:0] crc_in,
  output logic             tx_ready = 1'b0,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data
);
  logic [7:0] rx_q [$];
  logic [1:0] stall_q = 2'h0;
  // Memory holds one fixed word so readback bytes are predictable.
  assign read_word = (read_addr[1:0] == 2'h0) ? 32'h4433_2211 : 32'h0;
  assign crc_in    = 32'hA1B2_C3D4;
  // Takes each offered byte, refusing one cycle in three.
  always @(posedge clk)
  begin
    stall_q <= (stall_q == 2'h2) ? 2'h0 : stall_q + 2'h1;
    tx_ready <= (stall_q != 2'h1);
    if (tx_valid && tx_ready)
      rx_q.push_back(tx_data);
  end
endmodule : lrsec_host_model
`default_nettype wire

/* testbench/test_lrsec_core.sv */
// Self-checking bench for the loader response and security block.
`timescale 1ns/1ps
`default_nettype none
`include "lrsec_regs.svh"
module test_lrsec_core;
  localparam int BO = 60;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic        we = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        boot = 1'b0;
  logic [31:0] rdat, wb_dat_o, read_addr, read_word, crc_in;
  logic        ack, tx_ready, tx_valid, tx_crc_go, er_main, er_cfg;
  logic        l_exit, l_act;
  logic [7:0]  tx_data;
  logic [7:0]  rsp [0:31];
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc_n = 0;
  int          er_seen = 0;
  logic [31:0] ctl_word = 32'h1;
  lrsec_core #(.BACKOFF_CYC(BO)) i_lrsec_core (
    .clk, .srst, .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o,
    .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .boot_start(boot), .crc_in, .read_word, .read_addr,
    .tx_ready, .tx_valid, .tx_data, .tx_crc_go, .erase_main(er_main),
    .erase_cfg(er_cfg), .loader_exit(l_exit), .loader_active(l_act));
  lrsec_host_model i_lrsec_host_model (.clk, .read_addr, .read_word,
    .crc_in, .tx_ready, .tx_valid, .tx_data);
  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Counts erase pulses and cuts a hang short.
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (er_main && er_cfg)
      er_seen <= er_seen + 1;
    if (cyc_n == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check
  // One classic Wishbone cycle, held until acknowledge is sampled.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb
  task automatic do_reset();
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
  endtask : do_reset
  // Issues a command, waits until idle and collects exactly n bytes.
  task automatic cmd(input logic [7:0] c, input logic [31:0] a0, a1,
                     input int n);
    int k;
    wb(1'b1, `LRSEC_CMD_OFS, {24'h0, c});
    wb(1'b1, `LRSEC_ARG0_OFS, a0);
    wb(1'b1, `LRSEC_ARG1_OFS, a1);
    wb(1'b1, `LRSEC_CTRL_OFS, ctl_word);
    k = 0;
    while (i_lrsec_host_model.rx_q.size() < n && k < 400)
    begin
      @(posedge clk);
      k++;
    end
    k = 0;
    do
    begin
      wb(1'b0, `LRSEC_STATUS_OFS, 32'h0);
      k++;
    end while (rdat[8] !== 1'b0 && k < 100);
    check("byte count", i_lrsec_host_model.rx_q.size(), n);
    for (int i = 0; i < n; i++)
      rsp[i] = i_lrsec_host_model.rx_q.pop_front();
  endtask : cmd
  // Runs a command that must answer with a status packet.
  task automatic st(input logic [7:0] c, input logic [31:0] a0, a1,
                    input logic [7:0] s);
    cmd(c, a0, a1, 6);
    check("ack byte", rsp[0], `LRSEC_ACK);
    check("header", rsp[1], `LRSEC_HDR);
    check("length", {rsp[3], rsp[2]}, 32'h2);
    check("response code", rsp[4], `LRSEC_RSP_MSG);
    check("status byte", rsp[5], s);
  endtask : st
  // Checks the framing of a data answer of n data bytes.
  task automatic data_head(input logic [7:0] code, input int n);
    check("ack byte", rsp[0], `LRSEC_ACK);
    check("header", rsp[1], `LRSEC_HDR);
    check("length", {rsp[3], rsp[2]}, n + 1);
    check("response code", rsp[4], code);
  endtask : data_head
  // Loader entry needs boot start; register reads after reset.
  task automatic test_entry();
    do_reset();
    cmd(lrsec_pkg::LRSEC_CMD_CONNECT, 0, 0, 0);
    wb(1'b0, 8'h40, 32'h0);
    check("unmapped read", rdat, 32'h0);
    wb(1'b0, `LRSEC_CFG_OFS, 32'h0);
    check("cfg reset", rdat, {24'h0, `LRSEC_CFG_RST});
    boot <= 1'b1;
    wb(1'b0, `LRSEC_STATUS_OFS, 32'h0);
    check("active", rdat[3], 1'b1);
    $display("entry test done");
  endtask : test_entry
  // Every status code that a command can earn, except range and alert.
  task automatic test_status();
    st(lrsec_pkg::LRSEC_CMD_READ, 0, 4, lrsec_pkg::LRSEC_ST_INVALID);
    cmd(lrsec_pkg::LRSEC_CMD_CONNECT, 0, 0, 1);
    st(lrsec_pkg::LRSEC_CMD_READ, 0, 4, lrsec_pkg::LRSEC_ST_LOCKED);
    st(8'h77, 0, 0, lrsec_pkg::LRSEC_ST_UNKNOWN);
    wb(1'b1, `LRSEC_PWD_OFS, 32'h5A5A_1234);
    st(lrsec_pkg::LRSEC_CMD_UNLOCK, 1, 0, lrsec_pkg::LRSEC_ST_PWD);
    cmd(lrsec_pkg::LRSEC_CMD_CONNECT, 0, 0, 0);
    repeat (BO + 20) @(posedge clk);
    st(lrsec_pkg::LRSEC_CMD_UNLOCK, 32'h5A5A_1234, 0, 8'h00);
    st(lrsec_pkg::LRSEC_CMD_READ, 0, 4, lrsec_pkg::LRSEC_ST_READOUT);
    st(lrsec_pkg::LRSEC_CMD_PROGRAM, 4, 8, lrsec_pkg::LRSEC_ST_ALIGN);
    st(lrsec_pkg::LRSEC_CMD_PROGRAM, 0, 4, lrsec_pkg::LRSEC_ST_ALIGN);
    st(lrsec_pkg::LRSEC_CMD_VERIFY, 0, 32'h3FF, lrsec_pkg::LRSEC_ST_CRC_LEN);
    wb(1'b1, `LRSEC_CFG_OFS, 32'h84);
    st(lrsec_pkg::LRSEC_CMD_FACTORY, 0, 0, lrsec_pkg::LRSEC_ST_FR_OFF);
    wb(1'b1, `LRSEC_CFG_OFS, 32'h82);
    st(lrsec_pkg::LRSEC_CMD_FACTORY, 1, 0, lrsec_pkg::LRSEC_ST_FR_PWD);
    $display("status test done");
  endtask : test_status
  // Data answers, detailed flash error and relock on timeout.
  task automatic test_data();
    logic [31:0] iw;
    wb(1'b1, `LRSEC_CFG_OFS, 32'h81);
    st(lrsec_pkg::LRSEC_CMD_READ, 0, 32'h6C1, lrsec_pkg::LRSEC_ST_RANGE);
    cmd(lrsec_pkg::LRSEC_CMD_READ, 32'h100, 4, 9);
    data_head(`LRSEC_RSP_READ, 4);
    for (int i = 0; i < 4; i++)
      check("read data", rsp[5 + i], 8'h11 * (i + 1));
    cmd(lrsec_pkg::LRSEC_CMD_VERIFY, 0, 32'h400, 9);
    data_head(`LRSEC_RSP_CRC, 4);
    check("crc", {rsp[8], rsp[7], rsp[6], rsp[5]}, 32'hA1B2_C3D4);
    for (int k = 0; k < 5; k++)
      wb(1'b1, 8'(8'h24 + 4 * k), 32'h0403_0201 + 32'h1010_1010 * k);
    wb(1'b1, `LRSEC_APPVER_OFS, 32'hC4C3_C2C1);
    cmd(lrsec_pkg::LRSEC_CMD_INFO, 0, 0, 29);
    data_head(`LRSEC_RSP_INFO, 24);
    for (int j = 0; j < 24; j++)
    begin
      iw = 32'h0403_0201 + 32'h1010_1010 * ((j < 4) ? 0 : j / 4 - 1);
      if (j / 4 == 1)
        iw = 32'hC4C3_C2C1;
      check("info data", rsp[5 + j], iw[8 * (j % 4) +: 8]);
    end
    wb(1'b1, `LRSEC_FLSTAT_OFS, 32'hBEEF);
    ctl_word = 32'h5;
    cmd(lrsec_pkg::LRSEC_CMD_PROGRAM, 0, 8, 8);
    ctl_word = 32'h1;
    data_head(`LRSEC_RSP_DETAIL, 3);
    check("error type", rsp[5], `LRSEC_FLASH_ERR);
    check("error detail", {rsp[7], rsp[6]}, 32'hBEEF);
    wb(1'b1, `LRSEC_CTRL_OFS, 32'h2);
    st(lrsec_pkg::LRSEC_CMD_READ, 0, 4, lrsec_pkg::LRSEC_ST_LOCKED);
    $display("data test done");
  endtask : test_data
  // Three wrong passwords raise the alert: erase first, then disable.
  task automatic test_security();
    do_reset();
    cmd(lrsec_pkg::LRSEC_CMD_CONNECT, 0, 0, 1);
    wb(1'b1, `LRSEC_PWD_OFS, 32'h5A5A_1234);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
        wb(1'b1, `LRSEC_CFG_OFS, 32'h88);
      st(lrsec_pkg::LRSEC_CMD_UNLOCK, 2, 0, (i % 3 == 2) ? 8'h03 : 8'h02);
      repeat (BO + 20) @(posedge clk);
    end
    check("alert erase", er_seen, 1);
    check("alert exit", l_exit, 1'b1);
    wb(1'b0, `LRSEC_CFG_OFS, 32'h0);
    check("loader enable", rdat, 32'h08);
    $display("security test done");
  endtask : test_security
  initial
  begin
    test_entry();
    test_status();
    test_data();
    test_security();
    summarize();
  end
endmodule : test_lrsec_core
`default_nettype wire
